// *** logic/bcie_pkg.sv ***
// Operation
// - add literal to working, update C DC Z
// - file address 0..127, d picks destination
// - add working and file, C DC Z
// - and literal or file, only Z
// - or literal or file, only Z
// - clear or set one bit, no flags
// - skip next when tested bit clear
// - skip next when tested bit set
// - watchdog clear: counter, prescaler zero, flags one
// - call pushes return, loads target with latch bits
// - jump loads target, no push, two cycles
// - complement file to destination, only Z
// - clear file or working, Z set
// - decrement file to destination, only Z
// - increment file to destination, only Z
// - decrement, skip next when zero, no flags
// - move file to destination, Z updated
// - load literal into working, no flags
// - store working into file, no flags
// - interrupt return pops, sets global enable
// - subroutine return pops into counter, two cycles
// - return loads literal into working, pops
// - subtract working, carry means no borrow
// - sleep clears watchdog, timeout set, powerdown cleared
package bcie_pkg;
    // apb register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_WORK = 12'h008;
    localparam logic [11:0] REG_PC = 12'h00c;
    localparam logic [11:0] REG_UPPER = 12'h010;
    localparam logic [11:0] REG_IRQ = 12'h014;
    localparam logic [11:0] REG_WDOG = 12'h018;
    // control, interrupt and upper register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_WDOG_EN = 1;
    localparam int CTRL_WAKE = 2;
    localparam int IRQ_GLOBAL_EN = 7;
    localparam int UPPER_LO = 3;
    // reset values
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [13:0] NOP_WORD = 14'h0000;
    // instruction groups and opcodes
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    localparam logic [3:0] OPB_STORE = 4'h0;
    localparam logic [3:0] OPB_CLEAR = 4'h1;
    localparam logic [3:0] OPB_SUB = 4'h2;
    localparam logic [3:0] OPB_DEC = 4'h3;
    localparam logic [3:0] OPB_OR = 4'h4;
    localparam logic [3:0] OPB_AND = 4'h5;
    localparam logic [3:0] OPB_XOR = 4'h6;
    localparam logic [3:0] OPB_ADD = 4'h7;
    localparam logic [3:0] OPB_MOVE = 4'h8;
    localparam logic [3:0] OPB_COMP = 4'h9;
    localparam logic [3:0] OPB_INC = 4'ha;
    localparam logic [3:0] OPB_DECSKIP = 4'hb;
    localparam logic [3:0] OPB_RROT = 4'hc;
    localparam logic [3:0] OPB_LROT = 4'hd;
    localparam logic [3:0] OPB_SWAP = 4'he;
    localparam logic [3:0] OPB_INCSKIP = 4'hf;
    localparam logic [7:0] CTL_RETURN = 8'h08;
    localparam logic [7:0] CTL_IRET = 8'h09;
    localparam logic [7:0] CTL_SLEEP = 8'h63;
    localparam logic [7:0] CTL_WDCLR = 8'h64;
    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_SKIPC = 2'h2;
    localparam logic [1:0] BIT_SKIPS = 2'h3;

    typedef enum logic [2:0] {
        ST_HALT = 3'b000,
        ST_FETCH = 3'b001,
        ST_DECODE = 3'b010,
        ST_READ = 3'b011,
        ST_EXEC = 3'b100
    } bcie_state_t;

    typedef struct packed {
        logic c;
        logic dc;
        logic z;
    } bcie_flags_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic dc;
    } bcie_alu_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic we;
    } bcie_file_req_t;
endpackage : bcie_pkg

// *** logic/bcie_core.sv ***
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module bcie_core #(
    parameter int STACK_DEPTH = 8,
    parameter int WDOG_PRESCALE = 16
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [12:0] PROG_ADDR,
    input wire logic [13:0] PROG_DATA,
    output bcie_pkg::bcie_file_req_t FILE_REQ,
    input wire logic [7:0] FILE_RDATA,
    output logic SLEEPING
);
    localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
    localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);
    localparam int PS_W = (WDOG_PRESCALE > 1) ? $clog2(WDOG_PRESCALE) : 1;
    localparam logic [PS_W-1:0] PS_LAST = PS_W'(WDOG_PRESCALE - 1);

    bcie_pkg::bcie_state_t state_q;
    logic [13:0] ir_q;
    logic nop_q;
    logic hold_q;
    logic [12:0] pc_q;
    logic [7:0] w_q;
    bcie_pkg::bcie_flags_t flags_q;
    logic to_q;
    logic pd_q;
    logic sleep_q;
    logic [7:0] wdog_q;
    logic [PS_W-1:0] presc_q;
    logic [12:0] stack_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [12:0] prog_addr_q;
    bcie_pkg::bcie_file_req_t file_req_q;
    logic run_q;
    logic wdog_en_q;
    logic [4:0] upper_q;
    logic [7:0] irq_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // decoded results of the instruction in ir_q
    logic [7:0] res;
    logic wr_w;
    logic wr_f;
    bcie_pkg::bcie_flags_t flags_d;
    logic [12:0] pc_d;
    logic push;
    logic pop;
    logic dummy;
    logic hold;
    logic wdog_clr;
    logic go_sleep;
    logic set_gie;
    logic exec;
    logic apb_wr;
    logic apb_rd;
    logic wake;

    // add with carry in; subtraction passes the inverted working value and cin=1
    function automatic bcie_pkg::bcie_alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return '{res: s[7:0], c: s[8], dc: n[4]};
    endfunction : add8

    // instruction execute, evaluated every clock but only applied in ST_EXEC
    always_comb
    begin
        logic [7:0] f;
        logic [7:0] k;
        logic d;
        logic tbit;
        logic to_dest;
        logic upd_z;
        bcie_pkg::bcie_alu_t a;
        f = FILE_RDATA;
        k = ir_q[7:0];
        d = ir_q[7];
        tbit = f[ir_q[9:7]];
        to_dest = 1'b0;
        upd_z = 1'b0;
        a = '0;
        res = 8'h00;
        wr_w = 1'b0;
        wr_f = 1'b0;
        flags_d = flags_q;
        pc_d = hold_q ? pc_q : pc_q + 13'h0001;
        push = 1'b0;
        pop = 1'b0;
        dummy = 1'b0;
        hold = 1'b0;
        wdog_clr = 1'b0;
        go_sleep = 1'b0;
        set_gie = 1'b0;
        case (ir_q[13:12])
            bcie_pkg::GRP_BYTE:
            begin
                case (ir_q[11:8])
                    bcie_pkg::OPB_STORE:
                    begin
                        if (d)
                        begin
                            res = w_q;
                            wr_f = 1'b1;
                        end
                        else
                        begin
                            case (k)
                                bcie_pkg::CTL_RETURN:
                                begin
                                    pop = 1'b1;
                                    dummy = 1'b1;
                                    hold = 1'b1;
                                end
                                bcie_pkg::CTL_IRET:
                                begin
                                    pop = 1'b1;
                                    set_gie = 1'b1;
                                    dummy = 1'b1;
                                    hold = 1'b1;
                                end
                                bcie_pkg::CTL_SLEEP:
                                begin
                                    wdog_clr = 1'b1;
                                    go_sleep = 1'b1;
                                end
                                bcie_pkg::CTL_WDCLR: wdog_clr = 1'b1;
                                default: res = 8'h00;
                            endcase
                        end
                    end
                    bcie_pkg::OPB_CLEAR:
                    begin
                        res = 8'h00;
                        wr_f = d;
                        wr_w = ~d;
                        flags_d.z = 1'b1;
                    end
                    bcie_pkg::OPB_SUB:
                    begin
                        a = add8(f, ~w_q, 1'b1);
                        res = a.res;
                        flags_d.c = a.c;
                        flags_d.dc = a.dc;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_ADD:
                    begin
                        a = add8(f, w_q, 1'b0);
                        res = a.res;
                        flags_d.c = a.c;
                        flags_d.dc = a.dc;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_DEC,
                    bcie_pkg::OPB_DECSKIP:
                    begin
                        res = f - 8'h01;
                        to_dest = 1'b1;
                        upd_z = (ir_q[11:8] == bcie_pkg::OPB_DEC);
                        dummy = (ir_q[11:8] == bcie_pkg::OPB_DECSKIP) && (res == 8'h00);
                    end
                    bcie_pkg::OPB_INC,
                    bcie_pkg::OPB_INCSKIP:
                    begin
                        res = f + 8'h01;
                        to_dest = 1'b1;
                        upd_z = (ir_q[11:8] == bcie_pkg::OPB_INC);
                        dummy = (ir_q[11:8] == bcie_pkg::OPB_INCSKIP) && (res == 8'h00);
                    end
                    bcie_pkg::OPB_OR:
                    begin
                        res = w_q | f;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_AND:
                    begin
                        res = w_q & f;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_XOR:
                    begin
                        res = w_q ^ f;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_MOVE:
                    begin
                        res = f;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_COMP:
                    begin
                        res = ~f;
                        to_dest = 1'b1;
                        upd_z = 1'b1;
                    end
                    bcie_pkg::OPB_RROT:
                    begin
                        res = {flags_q.c, f[7:1]};
                        flags_d.c = f[0];
                        to_dest = 1'b1;
                    end
                    bcie_pkg::OPB_LROT:
                    begin
                        res = {f[6:0], flags_q.c};
                        flags_d.c = f[7];
                        to_dest = 1'b1;
                    end
                    default:
                    begin
                        res = {f[3:0], f[7:4]};
                        to_dest = 1'b1;
                    end
                endcase
            end
            bcie_pkg::GRP_BIT:
            begin
                res = f;
                res[ir_q[9:7]] = (ir_q[11:10] == bcie_pkg::BIT_SET);
                wr_f = (ir_q[11:10] == bcie_pkg::BIT_CLR) || (ir_q[11:10] == bcie_pkg::BIT_SET);
                if (ir_q[11:10] == bcie_pkg::BIT_SKIPC)
                begin
                    dummy = ~tbit;
                end
                if (ir_q[11:10] == bcie_pkg::BIT_SKIPS)
                begin
                    dummy = tbit;
                end
            end
            bcie_pkg::GRP_JUMP:
            begin
                // return address is the word after the call
                push = ~ir_q[11];
                pc_d = {upper_q[bcie_pkg::UPPER_LO+1:bcie_pkg::UPPER_LO], ir_q[10:0]};
                dummy = 1'b1;
                hold = 1'b1;
            end
            default:
            begin
                casez (ir_q[11:8])
                    4'b00??: res = k;
                    4'b01??:
                    begin
                        res = k;
                        pop = 1'b1;
                        dummy = 1'b1;
                        hold = 1'b1;
                    end
                    4'b1000:
                    begin
                        res = w_q | k;
                        upd_z = 1'b1;
                    end
                    4'b1001:
                    begin
                        res = w_q & k;
                        upd_z = 1'b1;
                    end
                    4'b1010:
                    begin
                        res = w_q ^ k;
                        upd_z = 1'b1;
                    end
                    4'b110?:
                    begin
                        a = add8(k, ~w_q, 1'b1);
                        res = a.res;
                        flags_d.c = a.c;
                        flags_d.dc = a.dc;
                        upd_z = 1'b1;
                    end
                    default:
                    begin
                        a = add8(w_q, k, 1'b0);
                        res = a.res;
                        flags_d.c = a.c;
                        flags_d.dc = a.dc;
                        upd_z = 1'b1;
                    end
                endcase
                wr_w = 1'b1;
            end
        endcase
        if (to_dest)
        begin
            wr_w = ~d;
            wr_f = d;
        end
        if (upd_z)
        begin
            flags_d.z = (res == 8'h00);
        end
        if (pop)
        begin
            pc_d = stack_q[sp_q - SP_ONE];
        end
    end

    assign exec = (state_q == bcie_pkg::ST_EXEC);
    assign apb_wr = PSEL && PENABLE && PWRITE && pready_q;
    assign apb_rd = PSEL && PENABLE && !pready_q;
    assign wake = apb_wr && (PADDR == bcie_pkg::REG_CTRL) && PWDATA[bcie_pkg::CTRL_WAKE];

    // four clocks per instruction cycle: fetch, decode, file read, execute
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            state_q <= bcie_pkg::ST_HALT;
        end
        else
        begin
            case (state_q)
                bcie_pkg::ST_HALT: state_q <= (run_q && !sleep_q) ? bcie_pkg::ST_FETCH : bcie_pkg::ST_HALT;
                bcie_pkg::ST_FETCH: state_q <= bcie_pkg::ST_DECODE;
                bcie_pkg::ST_DECODE: state_q <= bcie_pkg::ST_READ;
                bcie_pkg::ST_READ: state_q <= bcie_pkg::ST_EXEC;
                bcie_pkg::ST_EXEC: state_q <= (run_q && !go_sleep) ? bcie_pkg::ST_FETCH : bcie_pkg::ST_HALT;
                default: state_q <= bcie_pkg::ST_HALT;
            endcase
        end
    end

    // fetch side; a discarded word is replaced by a no-op in decode
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            prog_addr_q <= bcie_pkg::PC_RESET;
            ir_q <= bcie_pkg::NOP_WORD;
            file_req_q <= '0;
        end
        else
        begin
            file_req_q.we <= exec && wr_f;
            if (exec)
            begin
                file_req_q.wdata <= res;
            end
            if (state_q == bcie_pkg::ST_FETCH)
            begin
                prog_addr_q <= pc_q;
            end
            if (state_q == bcie_pkg::ST_DECODE)
            begin
                ir_q <= nop_q ? bcie_pkg::NOP_WORD : PROG_DATA;
                file_addr_update: file_req_q.addr <= PROG_DATA[6:0];
            end
        end
    end

    // architectural state written at the end of execute
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            pc_q <= bcie_pkg::PC_RESET;
            w_q <= bcie_pkg::WORK_RESET;
            flags_q <= '0;
            nop_q <= 1'b0;
            hold_q <= 1'b0;
            sp_q <= '0;
        end
        else if (exec)
        begin
            pc_q <= pc_d;
            flags_q <= flags_d;
            nop_q <= dummy; // second cycle runs as a no-op
            hold_q <= hold; // branches keep the loaded target through it
            if (wr_w)
            begin
                w_q <= res;
            end
            if (push)
            begin
                sp_q <= sp_q + SP_ONE;
            end
            else if (pop)
            begin
                sp_q <= sp_q - SP_ONE;
            end
        end
    end

    // return stack wraps silently when overfilled, as a fixed-depth ring
    always_ff @(posedge CLK)
    begin
        if (exec && push)
        begin
            stack_q[sp_q] <= pc_q + 13'h0001;
        end
    end

    // watchdog, prescaled by instruction cycles; wrap drops the timeout flag
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            wdog_q <= bcie_pkg::WDOG_RESET;
            presc_q <= '0;
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end
        else if (exec && wdog_clr)
        begin
            wdog_q <= bcie_pkg::WDOG_RESET;
            presc_q <= '0;
            to_q <= 1'b1;
            pd_q <= !go_sleep;
        end
        else if (exec && wdog_en_q)
        begin
            presc_q <= (presc_q == PS_LAST) ? '0 : presc_q + PS_W'(1);
            if (presc_q == PS_LAST)
            begin
                wdog_q <= wdog_q + 8'h01;
                if (wdog_q == 8'hff)
                begin
                    to_q <= 1'b0;
                end
            end
        end
    end

    // sleep: core stops until software wakes it; entering wins over a same-edge wake
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            sleep_q <= 1'b0;
        end
        else if (exec && go_sleep)
        begin
            sleep_q <= 1'b1;
        end
        else if (wake)
        begin
            sleep_q <= 1'b0;
        end
    end

    // software registers; the global enable set by the core wins over a write
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            run_q <= 1'b0;
            wdog_en_q <= 1'b0;
            upper_q <= '0;
            irq_q <= '0;
        end
        else
        begin
            if (apb_wr && PADDR == bcie_pkg::REG_CTRL)
            begin
                run_q <= PWDATA[bcie_pkg::CTRL_RUN];
                wdog_en_q <= PWDATA[bcie_pkg::CTRL_WDOG_EN];
            end
            if (apb_wr && PADDR == bcie_pkg::REG_UPPER)
            begin
                upper_q <= PWDATA[4:0];
            end
            if (apb_wr && PADDR == bcie_pkg::REG_IRQ)
            begin
                irq_q <= PWDATA[7:0];
            end
            if (exec && set_gie)
            begin
                irq_q[bcie_pkg::IRQ_GLOBAL_EN] <= 1'b1;
            end
        end
    end

    // apb slave: one wait state, read data captured with it
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= apb_rd;
            // error answer stands only with the ready cycle, never sticky into the next transfer
            pslverr_q <= 1'b0;
            if (apb_rd)
            begin
                case (PADDR)
                    bcie_pkg::REG_CTRL: prdata_q <= {30'h0, wdog_en_q, run_q};
                    bcie_pkg::REG_STATUS:
                        prdata_q <= {25'h0, state_q != bcie_pkg::ST_HALT, sleep_q, to_q, pd_q, flags_q.z,
                                     flags_q.dc, flags_q.c};
                    bcie_pkg::REG_WORK: prdata_q <= {24'h0, w_q};
                    bcie_pkg::REG_PC: prdata_q <= {19'h0, pc_q};
                    bcie_pkg::REG_UPPER: prdata_q <= {27'h0, upper_q};
                    bcie_pkg::REG_IRQ: prdata_q <= {24'h0, irq_q};
                    bcie_pkg::REG_WDOG: prdata_q <= {24'h0, wdog_q};
                    default:
                    begin
                        prdata_q <= '0;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PROG_ADDR = prog_addr_q;
    assign FILE_REQ = file_req_q;
    assign SLEEPING = sleep_q;
endmodule : bcie_core

// *** bench/bcie_core_sva.sv ***
`timescale 1ns/1ps
module bcie_core_sva (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [12:0] PROG_ADDR,
    input wire bcie_pkg::bcie_file_req_t FILE_REQ,
    input wire logic SLEEPING
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // one instruction cycle is four clocks, so the fetch address holds three more
    property p_step4;
        $changed(PROG_ADDR) |=> $stable(PROG_ADDR)[*3];
    endproperty
    a_step4: assert property (p_step4) else $error("fetch address moved inside a cycle");
    property p_we_gap;
        FILE_REQ.we |=> (!FILE_REQ.we)[*3];
    endproperty
    a_we_gap: assert property (p_we_gap) else $error("file write not a lone pulse");
    property p_addr_hold;
        FILE_REQ.we |-> $stable(FILE_REQ.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("file address moved at write");
    property p_sleep_still;
        SLEEPING && $past(SLEEPING) |-> $stable(PROG_ADDR) && !FILE_REQ.we;
    endproperty
    a_sleep_still: assert property (p_sleep_still) else $error("core active while asleep");
    property p_ack_wait;
        PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY;
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("bus answer not after one wait");
    property p_ack_one;
        PREADY |=> !PREADY;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ready held too long");
    property p_ack_access;
        PREADY |-> PSEL && PENABLE;
    endproperty
    a_ack_access: assert property (p_ack_access) else $error("ready outside access");
    property p_err_zero;
        PSLVERR |-> PREADY && PRDATA == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
    c_err: cover property (PSLVERR);
    c_write: cover property (FILE_REQ.we);
    c_sleep: cover property ($rose(SLEEPING));
endmodule : bcie_core_sva

// *** bench/bcie_mem_model.sv ***
`timescale 1ns/1ps
module bcie_mem_model (
    input wire logic CLK,
    input wire logic [12:0] PROG_ADDR,
    output logic [13:0] PROG_DATA,
    input wire bcie_pkg::bcie_file_req_t FILE_REQ,
    output logic [7:0] FILE_RDATA
);
    logic [13:0] prog_mem [128];
    logic [7:0] file_mem [128];
    // both memories answer at once; the core samples later than it needs
    assign PROG_DATA = prog_mem[PROG_ADDR[6:0]];
    assign FILE_RDATA = file_mem[FILE_REQ.addr];
    // write pulse lands one word, address held by the core
    always @(posedge CLK)
        if (FILE_REQ.we)
            file_mem[FILE_REQ.addr] <= FILE_REQ.wdata;
endmodule : bcie_mem_model

// *** bench/byte_core_instruction_execute_tb.sv ***
`timescale 1ns/1ps
module byte_core_instruction_execute_tb;
    logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, SLEEPING, er;
    logic [12:0] PROG_ADDR;
    logic [13:0] PROG_DATA;
    bcie_pkg::bcie_file_req_t FILE_REQ;
    logic [7:0] FILE_RDATA;
    int n_mismatch = 0, samples_checked = 0;
    // program: segments end in sleep, the last spins on a self jump at 25
    logic [13:0] code [26] = '{14'h300f, 14'h3ef1, 14'h0063, 14'h305a, 14'h00a0, 14'h07a0, 14'h0063,
        14'h3c10, 14'h39f0, 14'h380f, 14'h0920, 14'h0063, 14'h15a1, 14'h19a1, 14'h0aa1, 14'h1da1, 14'h3077,
        14'h0ba2, 14'h3066, 14'h11a1, 14'h01a3, 14'h0063, 14'h2040, 14'h00a4, 14'h0064, 14'h2819};
    logic [7:0] exp_w [5] = '{8'h00, 8'h5a, 8'h4b, 8'h4b, 8'h3c};
    logic [7:0] exp_st [5] = '{8'h17, 8'h12, 8'h10, 8'h14, 8'h1c};
    logic [7:0] exp_f [5] = '{8'hb4, 8'h01, 8'h00, 8'h00, 8'h3c};
    // at 64: nested call, return_literal_op; at 66: dec, increment_skip_zero_op skipping a bit clear, move for Z, interrupt return
    logic [13:0] sub_code [7] = '{14'h2042, 14'h343c, 14'h03a3, 14'h0fa3, 14'h1023, 14'h08a3, 14'h0009};
    bcie_core #(.WDOG_PRESCALE(2)) i_bcie_core (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .FILE_REQ(FILE_REQ), .FILE_RDATA(FILE_RDATA),
        .SLEEPING(SLEEPING));
    bcie_mem_model i_bcie_mem_model (.CLK(CLK), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
        .FILE_REQ(FILE_REQ), .FILE_RDATA(FILE_RDATA));
    // free running 100 MHz clock
    always #5 CLK = ~CLK;
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus transfer; request held until ready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do
        begin
            @(posedge CLK);
            k++;
        end
        while (PREADY !== 1'b1 && k < 20);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (k >= 20)
        begin
            n_mismatch++;
            complete_run();
        end
    endtask : apb
    // a few clocks first so a stale sleep level from before the wake is not taken
    task nap;
        int k;
        k = 0;
        while ((k < 3 || SLEEPING !== 1'b1) && k < 400)
        begin
            @(posedge CLK);
            k++;
        end
        if (k >= 400)
        begin
            n_mismatch++;
            complete_run();
        end
    endtask : nap
    // main sequence: load memories, run each segment, check state at every stop
    initial
    begin
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        foreach (code[i]) i_bcie_mem_model.prog_mem[i] = code[i];
        foreach (sub_code[i]) i_bcie_mem_model.prog_mem[64 + i] = sub_code[i];
        i_bcie_mem_model.file_mem[7'h21] = 8'h00;
        i_bcie_mem_model.file_mem[7'h22] = 8'h01;
        i_bcie_mem_model.file_mem[7'h23] = 8'h55;
        apb(1'b0, 12'h01c, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, bcie_pkg::REG_CTRL, 32'h1);
        for (int s = 0; s < 5; s++)
        begin
            if (s < 4)
                nap();
            else
                for (int k = 0; k < 40 && rd !== 32'd25; k++) apb(1'b0, bcie_pkg::REG_PC, 32'h0);
            apb(1'b0, bcie_pkg::REG_WORK, 32'h0);
            chk(rd, {24'h0, exp_w[s]});
            apb(1'b0, bcie_pkg::REG_STATUS, 32'h0);
            chk(rd & 32'h1f, {24'h0, exp_st[s]});
            if (s < 4)
                apb(1'b1, bcie_pkg::REG_CTRL, 32'h5);
        end
        apb(1'b0, bcie_pkg::REG_PC, 32'h0);
        chk(rd, 32'd25);
        apb(1'b0, bcie_pkg::REG_IRQ, 32'h0);
        chk(rd, 32'h80);
        for (int i = 0; i < 5; i++)
            chk({24'h0, i_bcie_mem_model.file_mem[7'h20 + i]}, {24'h0, exp_f[i]});
        complete_run();
    end
endmodule : byte_core_instruction_execute_tb
bind bcie_core bcie_core_sva i_bcie_core_sva (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PROG_ADDR(PROG_ADDR), .FILE_REQ(FILE_REQ),
    .SLEEPING(SLEEPING));
